// File: hw/csmzb_top.sv
// Purpose: memory-bus configuration straps and burst start logic
// Assumes: SYS_CLK at 200 MHz, much faster than the memory clock
// Notes: memory pins are sampled through two flops before use
//
// The APB slave port and the register offsets were chosen for this implementation.
module csmzb_top (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic STROBE_MODE_SELECT,
    input wire logic LINE_TRANSFER_COUNT_SEL,
    input wire logic MEMORY_WIDTH_SEL,
    input wire logic MEMORY_END_OF_CYCLE_N,
    input wire logic MEMORY_BURST_READY_N,
    input wire logic [7:0] MEMORY_DATA_PINS,
    output logic CLOCKED_MODE,
    output logic EIGHT_TRANSFERS,
    output logic NARROW_DATA,
    output logic ZERO_BASE_ARMED,
    output logic [2:0] BURST_ADDR
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // reload value: zero-based overrides the requested start
    function automatic logic [2:0] f_start(input logic zbt,
                                           input logic [2:0] req);
        f_start = zbt ? csmzb_pkg::START_ZERO : req;
    endfunction : f_start

    // interleaved order from the start; from zero it is linear
    function automatic logic [2:0] f_addr(input logic [2:0] start,
                                          input logic [2:0] step,
                                          input logic eight);
        logic [2:0] mask;
        mask = eight ? csmzb_pkg::MASK_EIGHT : csmzb_pkg::MASK_FOUR;
        f_addr = (start ^ step) & mask;
    endfunction : f_addr

    // ----------------------------------------------------------------
    // pin synchronisers and edge history
    // ----------------------------------------------------------------
    logic [csmzb_pkg::PIN_W-1:0] pins_s;
    csmzb_sync #(.W(csmzb_pkg::PIN_W)) u_sync (
        .clk(SYS_CLK),
        .d({STROBE_MODE_SELECT, LINE_TRANSFER_COUNT_SEL,
            MEMORY_WIDTH_SEL, MEMORY_END_OF_CYCLE_N,
            MEMORY_BURST_READY_N, MEMORY_DATA_PINS}),
        .q(pins_s)
    );

    wire mstb_s = pins_s[csmzb_pkg::PIN_MSTB];
    wire ltc_s = pins_s[csmzb_pkg::PIN_LTC];
    wire mw_s = pins_s[csmzb_pkg::PIN_MW];
    wire eoc_s = pins_s[csmzb_pkg::PIN_EOC];
    wire cpu_burst_ready_n_s = pins_s[csmzb_pkg::PIN_CPU_BURST_READY_N];
    wire [7:0] memory_data_pins_s = pins_s[csmzb_pkg::MEMORY_DATA_PINS_W-1:0];

    logic mstb_prev_reg;
    logic sel_prev_reg;
    logic eoc_prev_reg;
    logic cpu_burst_ready_n_prev_reg;

    // previous synced levels; history is valid after one edge
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            mstb_prev_reg <= 1'b0;
            sel_prev_reg <= 1'b1;
            eoc_prev_reg <= 1'b1;
            cpu_burst_ready_n_prev_reg <= 1'b1;
        end
        else
        begin
            mstb_prev_reg <= mstb_s;
            sel_prev_reg <= ltc_s;
            eoc_prev_reg <= eoc_s;
            cpu_burst_ready_n_prev_reg <= cpu_burst_ready_n_s;
        end
    end

    // ----------------------------------------------------------------
    // bus mode and strap capture
    // ----------------------------------------------------------------
    csmzb_pkg::csmzb_mode_e mode_reg;
    csmzb_pkg::csmzb_mode_e mode_next;
    logic clocked_reg;
    logic eight_reg;
    logic narrow_reg;

    wire mclk_rise = mstb_s && !mstb_prev_reg;
    wire strap_now = (mode_reg == csmzb_pkg::MODE_STRAP);

    // two rising edges count as a clock; a single step of a tied
    // level does not, so a slow strap settle stays in strobed mode
    always_comb
    begin
        mode_next = mode_reg;
        case (mode_reg)
            csmzb_pkg::MODE_STRAP:
                mode_next = csmzb_pkg::MODE_STROBED;
            csmzb_pkg::MODE_STROBED:
                if (mclk_rise)
                    mode_next = csmzb_pkg::MODE_EDGE1;
            csmzb_pkg::MODE_EDGE1:
                if (mclk_rise)
                    mode_next = csmzb_pkg::MODE_CLOCKED;
            csmzb_pkg::MODE_CLOCKED:
                mode_next = csmzb_pkg::MODE_CLOCKED;
            default:
                mode_next = csmzb_pkg::MODE_STRAP;
        endcase
    end

    // straps are taken once, at the first edge after release, from
    // synchroniser stages that kept tracking the pins during reset
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            mode_reg <= csmzb_pkg::MODE_STRAP;
            clocked_reg <= 1'b0;
            eight_reg <= 1'b0;
            narrow_reg <= 1'b0;
        end
        else
        begin
            mode_reg <= mode_next;
            clocked_reg <= (mode_next == csmzb_pkg::MODE_CLOCKED);
            if (strap_now)
            begin
                eight_reg <= !ltc_s;
                narrow_reg <= mw_s;
            end
        end
    end

    // ----------------------------------------------------------------
    // sampling points of the zero-based input
    // ----------------------------------------------------------------
    // after release the shared pins act as select and zero-based
    wire sel_act = !ltc_s;
    wire zbt_act = !mw_s;
    wire eoc_act = !eoc_s;
    wire cpu_burst_ready_n_act = !cpu_burst_ready_n_s;
    wire ck = (mode_reg == csmzb_pkg::MODE_CLOCKED) && mclk_rise;
    wire st = (mode_reg == csmzb_pkg::MODE_STROBED)
        || (mode_reg == csmzb_pkg::MODE_EDGE1);
    wire sel_fall = sel_prev_reg && !ltc_s;
    wire sel_rise = !sel_prev_reg && ltc_s;
    wire eoc_fall = eoc_prev_reg && !eoc_s;
    wire cpu_burst_ready_n_fall = cpu_burst_ready_n_prev_reg && !cpu_burst_ready_n_s;

    wire ck_idle = ck && !sel_act;
    wire ck_eoc = ck && sel_act && eoc_act;
    wire st_smp = st && (sel_fall || (eoc_fall && sel_act));
    wire smp_evt = ck_idle || ck_eoc || st_smp;
    wire rld_evt = smp_evt || (st && sel_rise);
    wire adv_evt = !rld_evt && sel_act
        && ((ck && cpu_burst_ready_n_act) || (st && cpu_burst_ready_n_fall));

    // ----------------------------------------------------------------
    // burst counter
    // ----------------------------------------------------------------
    logic zbt_used_reg;
    logic [2:0] start_reg;
    logic [2:0] step_reg;
    logic [2:0] burst_addr_reg;
    logic [2:0] cpu_start_reg;
    logic ovr_reg;
    csmzb_stream_if #(.WIDTH(csmzb_pkg::FIFO_W)) beat_in ();
    csmzb_stream_if #(.WIDTH(csmzb_pkg::FIFO_W)) beat_out ();

    // a beat only advances when the buffer takes it, so a full
    // buffer freezes the counter rather than skipping an item
    wire beat_taken = adv_evt && beat_in.ready;
    wire zbt_used_next = smp_evt ? zbt_act : zbt_used_reg;
    wire [2:0] start_next = rld_evt
        ? f_start(zbt_used_next, cpu_start_reg) : start_reg;
    wire [2:0] step_next = rld_evt ? 3'h0
        : (beat_taken ? step_reg + 3'h1 : step_reg);

    // counter and published burst address
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            zbt_used_reg <= 1'b0;
            start_reg <= 3'h0;
            step_reg <= 3'h0;
            burst_addr_reg <= 3'h0;
        end
        else
        begin
            zbt_used_reg <= zbt_used_next;
            start_reg <= start_next;
            step_reg <= step_next;
            burst_addr_reg <= f_addr(start_next, step_next, eight_reg);
        end
    end

    // narrow bus zeroes the unused upper data pins
    wire [7:0] beat_data = narrow_reg
        ? {4'h0, memory_data_pins_s[csmzb_pkg::NARROW_W-1:0]}
        : memory_data_pins_s;
    assign beat_in.data = {burst_addr_reg, beat_data};
    assign beat_in.valid = adv_evt;

    csmzb_fifo #(
        .WIDTH(csmzb_pkg::FIFO_W),
        .DEPTH(csmzb_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .wr(beat_in),
        .rd(beat_out)
    );

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;

    wire setup = PSEL && !PENABLE;
    wire done = PSEL && PENABLE && pready_reg;
    wire is_ctrl = (PADDR == csmzb_pkg::OFF_CTRL);
    wire is_status = (PADDR == csmzb_pkg::OFF_STATUS);
    wire is_data = (PADDR == csmzb_pkg::OFF_DATA);
    wire mapped = is_ctrl || is_status || is_data;
    wire ctrl_wr = done && PWRITE && is_ctrl;
    wire ovr_clr = ctrl_wr && PWDATA[csmzb_pkg::CTRL_OVR_CLR_BIT];
    // pop only a word that the setup cycle reported; one that lands
    // between setup and access stays for the next read
    assign beat_out.ready = done && !PWRITE && is_data
        && prdata_reg[csmzb_pkg::DATA_VALID_BIT];

    // read words, unused bits zero
    function automatic logic [31:0] f_status(input logic ck_m,
        input logic e8, input logic nar, input logic zb,
        input logic [2:0] ad, input logic ov, input logic av);
        f_status = csmzb_pkg::CTRL_RST;
        f_status[csmzb_pkg::ST_CLOCKED_BIT] = ck_m;
        f_status[csmzb_pkg::ST_EIGHT_BIT] = e8;
        f_status[csmzb_pkg::ST_NARROW_BIT] = nar;
        f_status[csmzb_pkg::ST_ZBT_BIT] = zb;
        f_status[csmzb_pkg::ST_ADDR_LSB +: 3] = ad;
        f_status[csmzb_pkg::ST_OVR_BIT] = ov;
        f_status[csmzb_pkg::ST_AVAIL_BIT] = av;
    endfunction : f_status

    wire [31:0] ctrl_word = {29'h0, cpu_start_reg};
    wire [31:0] stat_word = f_status(clocked_reg, eight_reg,
        narrow_reg, zbt_used_reg, burst_addr_reg, ovr_reg,
        beat_out.valid);
    wire [31:0] data_word = {15'h0, beat_out.valid, 5'h0,
        beat_out.data};
    wire [31:0] rd_word = is_ctrl ? ctrl_word
        : (is_status ? stat_word : (is_data ? data_word : 32'h0000_0000));

    // answer in the first access cycle; read data frozen at setup
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= csmzb_pkg::CTRL_RST;
        end
        else
        begin
            pready_reg <= setup;
            pslverr_reg <= setup && !mapped;
            if (setup)
                prdata_reg <= PWRITE ? csmzb_pkg::CTRL_RST : rd_word;
        end
    end

    // requested start and overrun flag; a new overrun beats a clear
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            cpu_start_reg <= csmzb_pkg::CTRL_RST[2:0];
            ovr_reg <= 1'b0;
        end
        else
        begin
            if (ctrl_wr)
                cpu_start_reg <= PWDATA[csmzb_pkg::CTRL_START_LSB +: 3];
            ovr_reg <= (adv_evt && !beat_in.ready) || (ovr_reg && !ovr_clr);
        end
    end

    // ----------------------------------------------------------------
    // outputs, all from flops
    // ----------------------------------------------------------------
    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign CLOCKED_MODE = clocked_reg;
    assign EIGHT_TRANSFERS = eight_reg;
    assign NARROW_DATA = narrow_reg;
    assign ZERO_BASE_ARMED = zbt_used_reg;
    assign BURST_ADDR = burst_addr_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    property p_strap_hold;
        !strap_now |=> $stable(eight_reg) && $stable(narrow_reg);
    endproperty
    a_strap_hold: assert property (p_strap_hold)
        else $error("strap value changed after capture");

    property p_strap_take;
        $fell(strap_now) |-> narrow_reg == $past(mw_s)
            && eight_reg == !$past(ltc_s);
    endproperty
    a_strap_take: assert property (p_strap_take)
        else $error("strap not captured at release");

    property p_static_strobed;
        (mode_reg == csmzb_pkg::MODE_STROBED) && !mclk_rise
            |=> !clocked_reg [*2];
    endproperty
    a_static_strobed: assert property (p_static_strobed)
        else $error("clocked mode without a clock");

    property p_clock_enter;
        (mode_reg == csmzb_pkg::MODE_EDGE1) && mclk_rise
            |=> clocked_reg && CLOCKED_MODE;
    endproperty
    a_clock_enter: assert property (p_clock_enter)
        else $error("second memory clock edge did not select clocked");

    property p_zero_start;
        ck_idle && zbt_act |=> BURST_ADDR == 3'h0 && ZERO_BASE_ARMED;
    endproperty
    a_zero_start: assert property (p_zero_start)
        else $error("zero-based reload not at address 0");

    property p_linear;
        (start_reg == 3'h0) && beat_taken && !rld_evt
            |=> BURST_ADDR == (($past(BURST_ADDR) + 3'h1)
                & (eight_reg ? 3'h7 : 3'h3));
    endproperty
    a_linear: assert property (p_linear)
        else $error("zero-based burst did not step linearly");

    property p_ignore;
        !smp_evt |=> $stable(zbt_used_reg);
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("zero-based value changed off a sample point");

    property p_eoc_sample;
        ck_eoc |=> zbt_used_reg == $past(zbt_act) && step_reg == 3'h0;
    endproperty
    a_eoc_sample: assert property (p_eoc_sample)
        else $error("end-of-cycle sample or reload missed");

    property p_strobe_sample;
        st && sel_fall |=> zbt_used_reg == $past(zbt_act);
    endproperty
    a_strobe_sample: assert property (p_strobe_sample)
        else $error("strobed select fall did not capture");

    property p_advance;
        ck && sel_act && cpu_burst_ready_n_act && !eoc_act && beat_in.ready
            |=> step_reg == $past(step_reg) + 3'h1;
    endproperty
    a_advance: assert property (p_advance)
        else $error("burst counter did not advance");

    property p_apb_answer;
        setup |=> PREADY ##1 !PREADY;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("apb answer not one access cycle");

    c_clocked: cover property (mode_reg == csmzb_pkg::MODE_CLOCKED);
    c_zero_beat: cover property (zbt_used_reg && beat_taken);
    c_fifo_full: cover property (adv_evt && !beat_in.ready);
    c_strobe_eoc: cover property (st && eoc_fall && sel_act);
endmodule : csmzb_top

// File: hw/csmzb_pkg.sv
// Purpose: shared constants and types of the zero-based burst slice
// Assumes: APB register bus with 32-bit data, byte addresses
// Notes: pin vector positions match the top-level synchroniser bundle
//
// How it works
// - a static level on the mode pin after reset selects strobed mode
// - a clock seen on the mode pin after reset enters clocked mode
// - the transfer count pin at reset picks four or eight transfers
// - transfer count pin becomes buffer select once reset is released
// - width pin high at reset uses only the low four data pins
// - width pin low at reset uses all eight data pins
// - width pin becomes the zero-based burst input after reset
// - zero-based burst sampled low starts the transfer at burst address 0
// - zero-based transfers step linearly upward from burst address 0
// - clocked: sample on idle select edges, use last one at select
// - clocked: also sample on edges with end-of-cycle and select active
// - strobed: capture on select fall and on end-of-cycle fall
// - zero-based input has no effect outside its sampling points
// - zero-based input is pulled up; unused systems drive it high
// - burst counter reloads on idle select and on end-of-cycle
// - clocked: select and burst ready advance the burst counter
package csmzb_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_DATA = 8'h08;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam int CTRL_START_LSB = 0;
    localparam int CTRL_OVR_CLR_BIT = 8;
    localparam int ST_CLOCKED_BIT = 0;
    localparam int ST_EIGHT_BIT = 1;
    localparam int ST_NARROW_BIT = 2;
    localparam int ST_ZBT_BIT = 3;
    localparam int ST_ADDR_LSB = 4;
    localparam int ST_OVR_BIT = 7;
    localparam int ST_AVAIL_BIT = 8;
    localparam int DATA_VALID_BIT = 16;
    // ----------------------------------------------------------------
    // widths, burst masks, pin bundle
    // ----------------------------------------------------------------
    localparam int BURST_AW = 3;
    localparam int MEMORY_DATA_PINS_W = 8;
    localparam int NARROW_W = 4;
    localparam int FIFO_W = BURST_AW + MEMORY_DATA_PINS_W;
    localparam int FIFO_DEPTH = 32;
    localparam logic [2:0] MASK_FOUR = 3'h3;
    localparam logic [2:0] MASK_EIGHT = 3'h7;
    localparam logic [2:0] START_ZERO = 3'h0;
    localparam int PIN_CPU_BURST_READY_N = 8;
    localparam int PIN_EOC = 9;
    localparam int PIN_MW = 10;
    localparam int PIN_LTC = 11;
    localparam int PIN_MSTB = 12;
    localparam int PIN_W = 13;
    // ----------------------------------------------------------------
    // bus mode state, gray along strap -> strobed -> edge -> clocked
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_STRAP = 2'b00,
        MODE_STROBED = 2'b01,
        MODE_EDGE1 = 2'b11,
        MODE_CLOCKED = 2'b10
    } csmzb_mode_e;
endpackage : csmzb_pkg

// File: hw/csmzb_stream_if.sv
// Purpose: valid/ready word stream between the slice and its buffer
// Assumes: a word moves on a clock edge with valid and ready high
// Notes: width is set by the instantiating module
interface csmzb_stream_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : csmzb_stream_if

// File: hw/csmzb_sync.sv
// Purpose: two-stage synchroniser for a bundle of pins
// Assumes: each bit is an independent level
// Notes: no reset so the stages track the pins while reset is held
module csmzb_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // first stage feeds only the second
    always_ff @(posedge clk)
    begin
        meta_reg <= d;
        q <= meta_reg;
    end
endmodule : csmzb_sync

// File: hw/csmzb_fifo.sv
// Purpose: flip-flop fifo holding captured memory beats
// Assumes: single clock, asynchronous active-high reset
// Notes: depth must be a power of two
module csmzb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    csmzb_stream_if.snk wr,
    csmzb_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wptr_reg;
    logic [AW:0] rptr_reg;
    wire full = (wptr_reg[AW] != rptr_reg[AW])
        && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
    wire empty = (wptr_reg == rptr_reg);
    wire push = wr.valid && wr.ready;
    wire pop = rd.valid && rd.ready;

    // honest flags; ready drops as soon as the last slot is taken
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data = mem_reg[rptr_reg[AW-1:0]];

    // pointers with a wrap bit tell full from empty
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end
        else
        begin
            wptr_reg <= wptr_reg + (AW+1)'(push);
            rptr_reg <= rptr_reg + (AW+1)'(pop);
        end
    end

    // storage is plain flops, written by index
    always_ff @(posedge clk)
    begin
        if (push)
            mem_reg[wptr_reg[AW-1:0]] <= wr.data;
    end

    property p_full_count;
        @(posedge clk) disable iff (rst)
        (push && !pop) |=> (wptr_reg - rptr_reg) != '0;
    endproperty
    a_full_count: assert property (p_full_count)
        else $error("fifo lost a pushed word");
endmodule : csmzb_fifo

// File: bench/csmzb_mbc_model.sv
// Purpose: memory bus controller model driving the memory pins
// Assumes: pins are asynchronous to the system clock
// Notes: the memory clock toggles only in ticks with run set
module csmzb_mbc_model (
    output logic mclk,
    output logic sel_n,
    output logic zb_n,
    output logic eoc_n,
    output logic cpu_burst_ready_n_n,
    output logic [7:0] memory_data_pins
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle: select off, zero-based input held high
    initial
    begin
        mclk = 1'b0;
        sel_n = 1'b1;
        zb_n = 1'b1;
        eoc_n = 1'b1;
        cpu_burst_ready_n_n = 1'b1;
        memory_data_pins = 8'h00;
    end
    // one 48 ns period; pins move while the clock is low
    // the mode pin carries this clock when run is set
    // cpu burst ready follows c[0], active low; beats drive it low
    task automatic tick(input logic run, input logic [3:0] c,
        input logic [7:0] d);
        #1;
        sel_n = c[3];
        zb_n = c[2];
        eoc_n = c[1];
        cpu_burst_ready_n_n = c[0];
        memory_data_pins = c[0] ? ~memory_data_pins : d; // idle data inverts each tick
        #23 mclk = run;
        #24 mclk = 1'b0;
    endtask : tick
endmodule : csmzb_mbc_model

// File: bench/cache_sram_membus_config_zero_burst_tb.sv
// Purpose: self-checking bench of the zero-based burst slice
// Assumes: apb answers by itself; memory pins are asynchronous
// Notes: straps reach the shared pins through the model
`define CHK(nm, e, g) \
    begin \
        checks_done++; \
        if ((g) !== (e)) \
        begin \
            fail_count++; \
            $display("unexpected %s exp %0h got %0h", nm, e, g); \
        end \
    end
module cache_sram_membus_config_zero_burst_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, mclk, sel_n, zb_n, eoc_n, cpu_burst_ready_n_n;
    logic clocked, eight, narrow, armed;
    logic [2:0] baddr, base;
    logic [7:0] memory_data_pins;
    logic [10:0] expq[$];
    logic [10:0] w;
    int fail_count = 0;
    int checks_done = 0;
    int seed = 32'h17e6_2f4d;
    int k;
    csmzb_mbc_model u_csmzb_mbc_model (.mclk(mclk), .sel_n(sel_n),
        .zb_n(zb_n), .eoc_n(eoc_n), .cpu_burst_ready_n_n(cpu_burst_ready_n_n), .memory_data_pins(memory_data_pins));
    csmzb_top u_csmzb_top (.SYS_CLK(sys_clk), .SYS_RST(sys_rst),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .STROBE_MODE_SELECT(mclk),
        .LINE_TRANSFER_COUNT_SEL(sel_n), .MEMORY_WIDTH_SEL(zb_n),
        .MEMORY_END_OF_CYCLE_N(eoc_n), .MEMORY_BURST_READY_N(cpu_burst_ready_n_n),
        .MEMORY_DATA_PINS(memory_data_pins), .CLOCKED_MODE(clocked),
        .EIGHT_TRANSFERS(eight), .NARROW_DATA(narrow),
        .ZERO_BASE_ARMED(armed), .BURST_ADDR(baddr));
    // 200 MHz system clock
    initial
    begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out
    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            fail_count++;
            close_out();
        end
    endtask : apb
    // straps sit on the shared pins across the release of reset
    task automatic do_reset(input logic ltc, input logic mw);
        sys_rst <= 1'b1;
        u_csmzb_mbc_model.sel_n <= ltc;
        u_csmzb_mbc_model.zb_n <= mw;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        u_csmzb_mbc_model.sel_n = 1'b1;
        u_csmzb_mbc_model.zb_n = 1'b1;
    endtask : do_reset
    function automatic logic [2:0] nxt(input int s);
        return (base ^ 3'(s)) & csmzb_pkg::MASK_FOUR;
    endfunction : nxt
    // one clocked beat; a full buffer drops it and holds the counter
    task automatic beat(input logic z);
        logic [7:0] d;
        d = 8'($random(seed));
        u_csmzb_mbc_model.tick(1'b1, {1'b0, z, 2'b10}, d);
        if (expq.size() < 32)
        begin
            expq.push_back({nxt(k), d});
            k++;
        end
        `CHK("addr", nxt(k), baddr)
    endtask : beat
    initial
    begin
        do_reset(1'b0, 1'b1);
        `CHK("eight", 1'b1, eight)
        `CHK("narrow", 1'b1, narrow)
        apb(1'b0, csmzb_pkg::OFF_STATUS, 32'h0000_0000);
        `CHK("status", 3'b110, rd[2:0])
        u_csmzb_mbc_model.tick(1'b0, 4'b1111, 8'h00);
        u_csmzb_mbc_model.tick(1'b0, 4'b0011, 8'h00);
        `CHK("armed", 1'b1, armed)
        u_csmzb_mbc_model.tick(1'b0, 4'b0111, 8'h00);
        `CHK("armed hold", 1'b1, armed)
        u_csmzb_mbc_model.tick(1'b0, 4'b0101, 8'h00);
        `CHK("armed eoc", 1'b0, armed)
        `CHK("strobed", 1'b0, clocked)
        u_csmzb_mbc_model.tick(1'b0, 4'b0110, 8'ha5);
        `CHK("strobed addr", 3'h1, baddr)
        apb(1'b0, csmzb_pkg::OFF_DATA, 32'h0000_0000);
        `CHK("narrow word", 17'h1_0005, rd[16:0])
        $display("strobed test done");
        do_reset(1'b1, 1'b0);
        `CHK("eight", 1'b0, eight)
        `CHK("narrow", 1'b0, narrow)
        base = 3'($random(seed)) & 3'h3 | 3'h1;
        apb(1'b1, csmzb_pkg::OFF_CTRL, {29'h0, base});
        repeat (3) u_csmzb_mbc_model.tick(1'b1, 4'b1011, 8'h00);
        `CHK("clocked", 1'b1, clocked)
        `CHK("armed", 1'b1, armed)
        `CHK("start", 3'h0, baddr)
        w = {8'h00, base};
        base = 3'h0;
        k = 0;
        repeat (3) beat(1'b1);
        `CHK("armed", 1'b1, armed)
        $display("zero-based test done");
        u_csmzb_mbc_model.tick(1'b1, 4'b0101, 8'h00);
        base = w[2:0];
        k = 0;
        `CHK("armed eoc", 1'b0, armed)
        `CHK("eoc start", base, baddr)
        repeat (33) beat(1'b0);
        apb(1'b0, csmzb_pkg::OFF_STATUS, 32'h0000_0000);
        `CHK("overrun", 1'b1, rd[7])
        apb(1'b1, csmzb_pkg::OFF_CTRL, {23'h0, 1'b1, 5'h0, base});
        apb(1'b0, csmzb_pkg::OFF_STATUS, 32'h0000_0000);
        `CHK("ovr clear", 1'b0, rd[7])
        $display("burst and overrun test done");
        while (expq.size() > 0)
        begin
            w = expq.pop_front();
            apb(1'b0, csmzb_pkg::OFF_DATA, 32'h0000_0000);
            `CHK("word", {1'b1, 5'h00, w}, rd[16:0] & 17'h1_07ff)
        end
        apb(1'b0, csmzb_pkg::OFF_DATA, 32'h0000_0000);
        `CHK("empty", 1'b0, rd[16])
        apb(1'b0, 8'h40, 32'h0000_0000);
        `CHK("slverr", 1'b1, err)
        `CHK("keep", 3'b001, {eight, narrow, clocked})
        $display("drain test done");
        close_out();
    end
endmodule : cache_sram_membus_config_zero_burst_tb
